// >>> rtl/tsw_pkg.sv
// Constants and types shared by the time-division switch control logic.
// Assumes a single 50 MHz core clock; all pins are synchronised inside the block.
package tsw_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int unsigned N_STREAMS   = 8;
  localparam int unsigned N_CHANNELS  = 32;
  localparam int unsigned N_LOCATIONS = 256;
  localparam int unsigned STREAM_W    = 3;
  localparam int unsigned CHAN_W      = 5;
  localparam int unsigned BIT_W       = 3;
  localparam int unsigned POS_W       = 8;
  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned CMH_W       = 3;

  // ****************************************
  // Address decode
  // ****************************************
  localparam int unsigned ADDR_MEM_BIT = 5;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int unsigned CTRL_SPLIT_BIT  = 7;
  localparam int unsigned CTRL_MSG_BIT    = 6;
  localparam int unsigned CTRL_SEL_HI     = 4;
  localparam int unsigned CTRL_SEL_LO     = 3;
  localparam int unsigned CTRL_STREAM_HI  = 2;
  localparam int unsigned CTRL_STREAM_LO  = 0;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;

  localparam logic [1:0] MSEL_RESERVED = 2'h0;
  localparam logic [1:0] MSEL_DATA     = 2'h1;
  localparam logic [1:0] MSEL_CML      = 2'h2;
  localparam logic [1:0] MSEL_CMH      = 2'h3;

  // ****************************************
  // Per-channel control memory fields
  // ****************************************
  localparam int unsigned CMH_MSG_BIT = 2;
  localparam int unsigned CMH_CST_BIT = 1;
  localparam int unsigned CMH_OE_BIT  = 0;
  localparam logic [2:0]  CMH_RESET   = 3'h0;
  localparam logic [7:0]  CML_RESET   = 8'h00;

  // ****************************************
  // Serial timing
  // ****************************************
  localparam int unsigned CLK_PER_BIT_LOG2 = 1;
  localparam int unsigned LAST_BIT         = 7;
  localparam int unsigned SYNC_STAGES      = 2;

  // Idle levels of the synchronised pins: chip select, bit clock and frame pulse high
  localparam logic [27:0] PIN_IDLE         = 28'h8000600;

  typedef enum logic {
    TSW_PORT_IDLE,
    TSW_PORT_ACK
  } tsw_port_state_t;

endpackage

// >>> rtl/tsw_switch.sv
// Control register, connection memories and serial switching of an 8 x 32 channel TDM switch.
// Assumes the processor port, bit clock, frame pulse and serial pins are asynchronous.
//
// What this block does
// - A5 low always reaches the control register
// - A5 high: A4-A0 pick channel 0-31
// - Select bits 4-3 choose memory; 00 forbidden
// - Bits 2-0 choose stream section of memory
// - Split mode: read data memory, write low
// - Global message mode sends low byte everywhere
// - Channel message bit sends low byte
// - Otherwise low byte addresses the data memory
// - High memory bits 7-3 read zero
// - Drive pin low floats all 8 serial stream outputs
// - Per-channel enable bit gates each driver, except in global message mode, which drives all
// - Control serial bit sent one channel early
// - Control bits ordered stream 0 first
// - Frames of 32 eight-bit channels repeat
// - Received bytes stored per stream and channel
// - Message byte repeats every frame until rewritten
`timescale 1ns/10ps
module tsw_switch (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       cs_n,
  input  wire logic       ds,
  input  wire logic       rd_wr_n,
  input  wire logic [5:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n,
  output logic            ack_out,
  output logic            ack_oe_n,
  input  wire logic       bit_clk_n,
  input  wire logic       frame_n,
  input  wire logic       output_drive_enable_pin,
  input  wire logic [7:0] serial_inputs,
  output logic      [7:0] serial_outputs,
  output logic      [7:0] serial_outputs_oe_n,
  output logic            control_serial_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int unsigned PIN_W = 28;

  logic [PIN_W-1:0] pins_async;
  logic [PIN_W-1:0] pins_sync;
  logic             cs_n_s;
  logic             ds_s;
  logic             rd_s;
  logic [5:0]       addr_s;
  logic [7:0]       din_s;
  logic             bclk_s;
  logic             frame_n_s;
  logic             ode_s;
  logic [7:0]       sti_s;

  assign pins_async = {cs_n, ds, rd_wr_n, addr, data_in, bit_clk_n, frame_n,
                       output_drive_enable_pin, serial_inputs};

  tsw_sync #(
    .WIDTH    (PIN_W),
    .RESET_VAL(tsw_pkg::PIN_IDLE)
  ) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  assign {cs_n_s, ds_s, rd_s, addr_s, din_s, bclk_s, frame_n_s, ode_s, sti_s} = pins_sync;

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] ctrl_reg;
  logic [7:0] dm_mem  [tsw_pkg::N_LOCATIONS];
  logic [7:0] cml_mem [tsw_pkg::N_LOCATIONS];
  logic [2:0] cmh_mem [tsw_pkg::N_LOCATIONS];

  // ****************************************
  // Processor port decode
  // ****************************************
  logic                   split_mode;
  logic                   global_msg;
  logic [1:0]             mem_sel;
  logic [2:0]             cur_stream;
  logic                   mem_access;
  logic [7:0]             mem_index;
  logic [7:0]             rd_mem_data;
  logic [7:0]             rd_data;
  logic                   wr_ctrl;
  logic                   wr_cml;
  logic                   wr_cmh;
  logic                   port_req;
  logic                   port_take;
  tsw_pkg::tsw_port_state_t port_state_reg;
  tsw_pkg::tsw_port_state_t port_state_next;

  // Bit 5 is stored and read back but nothing decodes it
  // bit 5 unused
  assign split_mode = ctrl_reg[tsw_pkg::CTRL_SPLIT_BIT];
  assign global_msg = ctrl_reg[tsw_pkg::CTRL_MSG_BIT];
  assign mem_sel    = ctrl_reg[tsw_pkg::CTRL_SEL_HI:tsw_pkg::CTRL_SEL_LO];
  assign cur_stream = ctrl_reg[tsw_pkg::CTRL_STREAM_HI:tsw_pkg::CTRL_STREAM_LO];

  assign mem_access = addr_s[tsw_pkg::ADDR_MEM_BIT];
  assign mem_index  = {cur_stream, addr_s[tsw_pkg::CHAN_W-1:0]};

  assign rd_mem_data = (split_mode || mem_sel == tsw_pkg::MSEL_DATA) ? dm_mem[mem_index] :
                       (mem_sel == tsw_pkg::MSEL_CML)                ? cml_mem[mem_index] :
                       (mem_sel == tsw_pkg::MSEL_CMH)                ? {5'h00, cmh_mem[mem_index]} :
                                                                       8'h00;
  assign rd_data     = mem_access ? rd_mem_data : ctrl_reg;

  assign port_req  = !cs_n_s && ds_s;
  assign port_take = (port_state_reg == tsw_pkg::TSW_PORT_IDLE) && port_req;

  // writes to data memory or reserved code dropped, except in split mode, where they go to low memory
  assign wr_ctrl = port_take && !rd_s && !mem_access;
  assign wr_cml  = port_take && !rd_s && mem_access &&
                   (split_mode || mem_sel == tsw_pkg::MSEL_CML);
  assign wr_cmh  = port_take && !rd_s && mem_access &&
                   !split_mode && mem_sel == tsw_pkg::MSEL_CMH;

  always_comb begin
    port_state_next = port_state_reg;
    unique case (port_state_reg)
      tsw_pkg::TSW_PORT_IDLE: begin
        if (port_req) begin
          port_state_next = tsw_pkg::TSW_PORT_ACK;
        end
      end
      tsw_pkg::TSW_PORT_ACK: begin
        if (!port_req) begin
          port_state_next = tsw_pkg::TSW_PORT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_state_reg <= tsw_pkg::TSW_PORT_IDLE;
      data_out       <= 8'h00;
    end else begin
      port_state_reg <= port_state_next;
      if (port_take && rd_s) begin
        data_out <= rd_data;
      end
    end
  end

  // Acknowledge is open drain: pulled low while the access is held
  assign ack_out   = 1'b0;
  assign ack_oe_n  = (port_state_reg != tsw_pkg::TSW_PORT_ACK);
  assign data_oe_n = !((port_state_reg == tsw_pkg::TSW_PORT_ACK) && rd_s);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= tsw_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= din_s;
    end
  end

  // low byte held until processor rewrites it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < tsw_pkg::N_LOCATIONS; i++) begin
        cml_mem[i] <= tsw_pkg::CML_RESET;
        cmh_mem[i] <= tsw_pkg::CMH_RESET;
      end
    end else begin
      if (wr_cml) begin
        cml_mem[mem_index] <= din_s;
      end
      if (wr_cmh) begin
        cmh_mem[mem_index] <= din_s[tsw_pkg::CMH_W-1:0];
      end
    end
  end

  // ****************************************
  // Serial frame timing
  // ****************************************
  logic                          bclk_d_reg;
  logic                          bclk_edge;
  logic [tsw_pkg::CLK_PER_BIT_LOG2-1:0] half_reg;
  logic                          bit_tick;
  logic [tsw_pkg::POS_W-1:0]     pos_reg;
  logic [tsw_pkg::POS_W-1:0]     pos_next;
  logic [tsw_pkg::CHAN_W-1:0]    cur_chan;
  logic [tsw_pkg::BIT_W-1:0]     cur_bit;
  logic                          chan_end;
  logic [tsw_pkg::CHAN_W-1:0]    nxt_chan;
  logic [tsw_pkg::BIT_W-1:0]     nxt_bit;
  logic [tsw_pkg::CHAN_W-1:0]    early_chan;

  assign bclk_edge = bclk_s && !bclk_d_reg;
  assign bit_tick  = bclk_edge && (&half_reg);

  // 32 channels of 8 bits per frame
  assign pos_next   = pos_reg + 8'h01;
  assign cur_chan   = pos_reg[tsw_pkg::POS_W-1:tsw_pkg::BIT_W];
  assign cur_bit    = pos_reg[tsw_pkg::BIT_W-1:0];
  assign chan_end   = bit_tick && (cur_bit == 3'(tsw_pkg::LAST_BIT));
  assign nxt_chan   = pos_next[tsw_pkg::POS_W-1:tsw_pkg::BIT_W];
  assign nxt_bit    = pos_next[tsw_pkg::BIT_W-1:0];
  assign early_chan = nxt_chan + 5'h01;

  // Frame pulse realigns to channel 0 bit 0
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bclk_d_reg <= 1'b1;
      half_reg   <= '0;
      pos_reg    <= 8'h00;
    end else begin
      bclk_d_reg <= bclk_s;
      if (bclk_edge && !frame_n_s) begin
        half_reg <= '0;
        pos_reg  <= 8'h00;
      end else if (bclk_edge) begin
        half_reg <= half_reg + 1'b1;
        if (bit_tick) begin
          pos_reg <= pos_next;
        end
      end
    end
  end

  // ****************************************
  // Per-stream receive and transmit
  // ****************************************
  logic [7:0] rx_byte [tsw_pkg::N_STREAMS];

  genvar s;
  generate
    for (s = 0; s < tsw_pkg::N_STREAMS; s++) begin : g_stream
      logic [7:0] rx_sh_reg;
      logic [7:0] src_loc;
      logic [2:0] ctl_bits;
      logic       msg_sel;
      logic [7:0] tx_byte;
      logic       drive;

      assign src_loc  = {3'(s), nxt_chan};
      assign ctl_bits = cmh_mem[src_loc];
      assign msg_sel  = global_msg || ctl_bits[tsw_pkg::CMH_MSG_BIT];
      // low byte as data memory address
      assign tx_byte  = msg_sel ? cml_mem[src_loc] : dm_mem[cml_mem[src_loc]];
      assign drive    = ode_s && (global_msg || ctl_bits[tsw_pkg::CMH_OE_BIT]);
      assign rx_byte[s] = {rx_sh_reg[6:0], sti_s[s]};

      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          rx_sh_reg              <= 8'h00;
          serial_outputs[s]      <= 1'b0;
          serial_outputs_oe_n[s] <= 1'b1;
        end else begin
          if (bit_tick) begin
            rx_sh_reg              <= rx_byte[s];
            serial_outputs[s]      <= tx_byte[3'(tsw_pkg::LAST_BIT) - nxt_bit];
            serial_outputs_oe_n[s] <= !drive;
          end
          if (!ode_s) begin
            serial_outputs_oe_n[s] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // store received byte by stream and channel
  always_ff @(posedge ref_clk) begin
    if (chan_end) begin
      for (int i = 0; i < tsw_pkg::N_STREAMS; i++) begin
        dm_mem[{3'(i), cur_chan}] <= rx_byte[i];
      end
    end
  end

  // ****************************************
  // Control serial output
  // ****************************************
  logic [7:0] cst_loc;

  // bit slot selects stream, stream 0 first
  assign cst_loc = {nxt_bit, early_chan};

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_serial_out <= 1'b0;
    end else if (bit_tick) begin
      control_serial_out <= cmh_mem[cst_loc][tsw_pkg::CMH_CST_BIT];
    end
  end

endmodule

// >>> rtl/tsw_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pin inputs.
// Assumes each bit is independent; multi-bit buses must be stable when sampled.
`timescale 1ns/10ps
module tsw_sync #(
  parameter int unsigned          WIDTH     = 1,
  parameter logic [WIDTH-1:0]     RESET_VAL = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // Reset to the pins' idle level so that no false edge follows reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= RESET_VAL;
      sync_out   <= RESET_VAL;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// >>> test/tb_tsw_switch.sv
// Self-checking bench for the switch register and serial paths.
// Assumes tsw_cpu_model drives the port and the checker is bound.
`timescale 1ns/10ps
module tb_tsw_switch;
  logic        ref_clk, arst_n, bit_clk_n, frame_n, drv_en;
  logic        cs_n, ds, rd_wr_n, data_oe_n, ack_out, ack_oe_n, cso;
  logic [5:0]  addr;
  logic [7:0]  data_in, data_out, si, so, so_oe_n;
  logic [0:63] so_v, oe_v, cs_v;
  int          fail_count = 0;
  int          cmp_count = 0;

  tsw_switch dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .ds(ds),
    .rd_wr_n(rd_wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .ack_out(ack_out), .ack_oe_n(ack_oe_n),
    .bit_clk_n(bit_clk_n), .frame_n(frame_n), .output_drive_enable_pin(drv_en),
    .serial_inputs(si), .serial_outputs(so), .serial_outputs_oe_n(so_oe_n),
    .control_serial_out(cso));
  tsw_cpu_model cpu_u (.ref_clk(ref_clk), .cs_n(cs_n), .ds(ds), .rd_wr_n(rd_wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .ack_oe_n(ack_oe_n));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t byte %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       ok;
    cpu_u.xfer(1'b0, a, d, q, ok);
    chkb(ok, 1'b1);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       ok;
    cpu_u.xfer(1'b1, a, 8'h00, q, ok);
    chkb(ok, 1'b1);
    chk8(q, exp);
  endtask

  // one frame of 32 channels of 8 bits, sampled late in each of the first 64 bits
  task automatic frame();
    for (int b = 0; b < 256; b++) begin
      for (int h = 0; h < 4; h++) begin
        if (h == 3 && b < 64) begin
          so_v[b] = so[0];
          oe_v[b] = so_oe_n[0];
          cs_v[b] = cso;
        end
        bit_clk_n <= h[0];
        frame_n <= (b != 0) || (h > 1);
        repeat (3) @(posedge ref_clk);
      end
    end
  endtask

  function automatic logic hit(input logic [0:63] v, input int c, input logic [7:0] p);
    logic [7:0] w;
    for (int j = 0; j < 8; j++) begin
      w[7 - j] = v[8 * c + j];
    end
    hit = (w === p);
  endfunction

  task automatic t_regs();
    wr(6'h15, 8'h3B);
    rd(6'h00, 8'h3B);
    chkb(ack_out, 1'b0);
    wr(6'h25, 8'hFF);
    rd(6'h25, 8'h07);
    rd(6'h26, 8'h00);
    wr(6'h00, 8'h13);
    rd(6'h25, 8'h00);
    wr(6'h25, 8'h5A);
    rd(6'h25, 8'h5A);
    wr(6'h00, 8'h14);
    rd(6'h25, 8'h00);
    wr(6'h00, 8'h03);
    wr(6'h25, 8'h77);
    rd(6'h25, 8'h00);
    wr(6'h00, 8'h0B);
    rd(6'h25, 8'h00);
    wr(6'h25, 8'h66);
    rd(6'h25, 8'h00);
    wr(6'h00, 8'h13);
    rd(6'h25, 8'h5A);
    $display("test regs done");
  endtask

  task automatic t_split();
    wr(6'h00, 8'h84);
    rd(6'h27, 8'hFF);
    wr(6'h27, 8'hC3);
    wr(6'h00, 8'h14);
    rd(6'h27, 8'hC3);
    $display("test split done");
  endtask

  task automatic t_msg();
    wr(6'h00, 8'h10);
    wr(6'h22, 8'hA5);
    wr(6'h00, 8'h50);
    frame();
    chkb(hit(so_v, 2, 8'hA5), 1'b1);
    frame();
    chkb(hit(so_v, 2, 8'hA5), 1'b1);
    chk8(8'(64 - $countones(oe_v)), 8'h40);
    drv_en <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk8(so_oe_n, 8'hFF);
    drv_en <= 1'b1;
    $display("test message done");
  endtask

  task automatic t_chan();
    wr(6'h00, 8'h18);
    wr(6'h22, 8'h05);
    wr(6'h23, 8'h01);
    wr(6'h24, 8'h02);
    wr(6'h00, 8'h10);
    wr(6'h23, 8'h80);
    frame();
    chkb(hit(so_v, 2, 8'hA5), 1'b1);
    chkb(hit(so_v, 3, 8'hFF), 1'b1);
    chk8(8'(64 - $countones(oe_v)), 8'h10);
    chk8(8'($countones(cs_v)), 8'h02);
    chkb(cs_v[24], 1'b1);
    chkb(cs_v[35], 1'b1);
    $display("test channel done");
  endtask

  initial begin
    arst_n = 1'b0;
    bit_clk_n = 1'b1;
    frame_n = 1'b1;
    drv_en = 1'b1;
    si = 8'hF0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    frame();
    t_regs();
    t_split();
    t_msg();
    t_chan();
    close_out();
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
endmodule

// >>> test/tsw_cpu_model.sv
// Processor model for the strobe and acknowledge port.
// Assumes xfer is called from one process, aligned to ref_clk.
`timescale 1ns/10ps
module tsw_cpu_model (
  input  wire logic       ref_clk,
  output logic            cs_n,
  output logic            ds,
  output logic            rd_wr_n,
  output logic      [5:0] addr,
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       ack_oe_n
);
  initial begin
    cs_n = 1'b1;
    ds = 1'b0;
    rd_wr_n = 1'b1;
    addr = 6'h00;
    data_in = 8'h00;
  end

  // Request held until ack is sampled low or 20 cycles pass, then released
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    ok = 1'b0;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    ds <= 1'b1;
    rd_wr_n <= rd;
    addr <= a;
    data_in <= d;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge ref_clk);
      ok = (ack_oe_n === 1'b0);
    end
    q = data_out;
    cs_n <= 1'b1;
    ds <= 1'b0;
    addr <= ~a;
    data_in <= ~d;
    for (int n = 0; n < 20 && ack_oe_n !== 1'b1; n++) begin
      @(posedge ref_clk);
    end
  endtask
endmodule

// >>> test/tsw_switch_checker.sv
// Port checker for tsw_switch.
// Assumes it is bound into tsw_switch and sees only its ports.
`timescale 1ns/10ps
module tsw_switch_checker (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       cs_n,
  input wire logic       ds,
  input wire logic       rd_wr_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n,
  input wire logic       ack_oe_n,
  input wire logic       output_drive_enable_pin,
  input wire logic [7:0] serial_outputs_oe_n
);
  logic [7:0] ctrl_reg;
  logic       rd_take;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // ****************************************
  // Shadow of the control register
  // ****************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= 8'h00;
    end else if ($fell(ack_oe_n) && !rd_wr_n && !addr[5]) begin
      ctrl_reg <= data_in;
    end
  end

  assign rd_take = rd_wr_n && !cs_n && ds;

  ack_idle_a: assert property (cs_n [*4] |-> ack_oe_n)
    else $error("ack driven without chip select");
  ack_drop_a: assert property (!ds [*4] |-> ack_oe_n)
    else $error("ack held after strobe dropped");
  ack_give_a: assert property ((ds && !cs_n) [*4] |-> !ack_oe_n)
    else $error("held request not acknowledged");
  ack_hold_a: assert property (!ack_oe_n && ds && $past(ds) && $past(ds, 2) && !cs_n
                               && !$past(cs_n) && !$past(cs_n, 2) |=> !ack_oe_n)
    else $error("ack released under held request");
  rd_drive_a: assert property ($fell(ack_oe_n) |-> data_oe_n == !rd_wr_n)
    else $error("data drive disagrees with direction");
  ctrl_read_a: assert property ($fell(ack_oe_n) && rd_take && !addr[5]
                                |-> data_out == ctrl_reg)
    else $error("control read mismatch");
  high_zero_a: assert property ($fell(ack_oe_n) && rd_take && addr[5] && !ctrl_reg[7]
                                && ctrl_reg[4:3] == 2'h3 |-> data_out[7:3] == 5'h00)
    else $error("high memory upper bits not zero");
  rsv_read_a: assert property ($fell(ack_oe_n) && rd_take && addr[5] && !ctrl_reg[7]
                               && ctrl_reg[4:3] == 2'h0 |-> data_out == 8'h00)
    else $error("reserved select read not zero");
  ode_off_a: assert property (!output_drive_enable_pin [*4]
                              |-> serial_outputs_oe_n == 8'hFF)
    else $error("outputs driven with drive pin low");
endmodule

bind tsw_switch tsw_switch_checker chk_u (
  .ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .ds(ds), .rd_wr_n(rd_wr_n),
  .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
  .ack_oe_n(ack_oe_n), .output_drive_enable_pin(output_drive_enable_pin),
  .serial_outputs_oe_n(serial_outputs_oe_n)
);
